// ===== core_model.sv
// core side: enters a pending handler after wait_i cycles, returns on ret_i
// assumes the bench drives go_i, wait_i and ret_i after rising edges
`timescale 1ns/1ps
module core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req_i,
	input  wire logic       go_i,
	input  wire logic [3:0] wait_i,
	input  wire logic       ret_i,
	output logic            take_o,
	output logic            done_o
);
	logic [3:0] age_reg;
	logic [1:0] cool_reg;
	// ==========
	// cool-down stops a second entry while the request falls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			take_o   <= 1'b0;
			done_o   <= 1'b0;
			age_reg  <= 4'h0;
			cool_reg <= 2'h0;
		end else begin
			take_o <= 1'b0;
			done_o <= ret_i;
			if (cool_reg != 2'h0) begin
				cool_reg <= cool_reg - 2'h1;
			end else if (go_i && req_i) begin
				age_reg <= age_reg + 4'h1;
				if (age_reg >= wait_i) begin
					take_o   <= 1'b1;
					cool_reg <= 2'h3;
					age_reg  <= 4'h0;
				end
			end else begin
				age_reg <= 4'h0;
			end
		end
	end
endmodule

// ===== irq_unit.sv
// interrupt enable, pin source selection and two-level priority unit
// assumes: synchronous pin inputs, level requests from peripherals,
// core pulses take_i on handler entry and done_i on handler return
//
// Summary of operation
// - basic mask bits 5..0 allow timer2, serial0, timer1, ext1, timer0, ext0.
// - extended mask bits 7..0 allow watchdog, pin group, pwm, serial1, adc, usb, touch, spi.
// - pin group allow bit gates all selected pin sources together.
// - level mode: pin request follows active level of any selected pin.
// - edge mode: valid edge latches flag; cleared by level mode, reset, pin group handler entry.
// - select bits 5,4,3,1 pick port1 pins 5,4,3 and port3 pin1, active low.
// - select bit 2 picks reset pin, active high, rising edge.
// - select bits 6 and 0 pick serial receive pins, chosen by remap bits.
// - priority bit set means high level, clear means low level.
// - basic priority bits 5..0 map timer2, serial0, timer1, ext1, timer0, ext0.
// - extended priority bits 6..0 map pin group, pwm, serial1, adc, usb, touch, spi.
// - within one level, fixed default order picks the winner.
// - running flags 00 none, 01 low, 10 high, 11 error.
// - nesting flag reads 1 only at depth one.
// - sources 0..13 in default order; vector 0x0003 plus eight per source.
// - requests pass only with global allow set and global block clear.
// - pin request active reads as bit 6 of pin function register.
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module irq_unit (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         cyc_i,
	input  wire logic         stb_i,
	input  wire logic         we_i,
	input  wire logic         sel_i,
	input  wire logic [3:0]   adr_i,
	input  wire logic [7:0]   dat_i,
	output logic      [7:0]   dat_o,
	output logic              ack_o,
	output logic              int_o,
	input  wire logic [13:0]  src_req_i,
	input  wire logic         p1_2_i,
	input  wire logic         p1_3_i,
	input  wire logic         p1_4_i,
	input  wire logic         p1_5_i,
	input  wire logic         p1_6_i,
	input  wire logic         p3_0_i,
	input  wire logic         p3_1_i,
	input  wire logic         p3_4_i,
	input  wire logic         rst_pin_i,
	input  wire logic         take_i,
	input  wire logic         done_i,
	output logic              irq_req_o,
	output logic      [3:0]   irq_num_o,
	output logic      [15:0]  irq_vector_o,
	output logic              high_run_o,
	output logic              low_run_o
);
	import irq_unit_pkg::*;

	// ==================================
	// helpers
	function automatic logic [4:0] first_set(input logic [13:0] v);
		logic [4:0] r;
		r = 5'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// ==================================
	// registers
	logic [7:0] basic_mask_reg;
	logic [7:0] extended_mask_reg;
	logic [7:0] pin_source_select_reg;
	logic [5:0] basic_priority_reg;
	logic [6:0] extended_priority_reg;
	logic       serial1_pin_remap;
	logic       serial0_pin_remap;
	logic [2:0] evt_status_reg;
	logic [2:0] evt_mask_reg;
	logic [6:0] pin_act_prev_reg;
	logic       pin_edge_flag_reg;
	logic [1:0] depth_reg;
	logic [1:0] level_stack_reg;
	logic       ack_reg;
	logic [7:0] dat_reg;
	logic       int_reg;
	logic       irq_req_reg;
	logic [3:0] irq_num_reg;
	logic [15:0] irq_vector_reg;
	logic       high_run_reg;
	logic       low_run_reg;

	logic       bus_go;
	logic       wr_go;
	logic       pin_edge_mode;
	logic [6:0] pin_act;
	logic [6:0] pin_edges;
	logic       pin_request_active;
	logic [13:0] src_raw;
	logic [13:0] src_allow;
	logic [13:0] src_high;
	logic [13:0] pend;
	logic       gate_open;
	logic [4:0] pick_high;
	logic [4:0] pick_low;
	logic       top_is_high;
	logic       high_level_running;
	logic       low_level_running;
	logic       nesting_depth_flag;
	logic       can_high;
	logic       can_low;
	logic       sel_valid;
	logic [3:0] sel_num;
	logic       sel_high;
	logic       entry;
	logic [2:0] evt_set;

	assign bus_go = cyc_i & stb_i & ~ack_reg;
	// writes land at the edge that samples ack high
	assign wr_go  = cyc_i & stb_i & ack_reg & we_i & sel_i;

	// ==================================
	// pin sources
	assign pin_edge_mode = pin_source_select_reg[PIN_EDGE_BIT];

	assign pin_act[6] = ~(serial1_pin_remap ? p3_4_i : p1_6_i);
	assign pin_act[0] = ~(serial0_pin_remap ? p1_2_i : p3_0_i);
	assign pin_act[5] = ~p1_5_i;
	assign pin_act[4] = ~p1_4_i;
	assign pin_act[3] = ~p1_3_i;
	assign pin_act[1] = ~p3_1_i;
	assign pin_act[2] = rst_pin_i;

	assign pin_edges = pin_act & ~pin_act_prev_reg
		& pin_source_select_reg[NUM_PINS-1:0];

	// level follows pins, edge uses flag
	assign pin_request_active = pin_edge_mode ? pin_edge_flag_reg
		: |(pin_act & pin_source_select_reg[NUM_PINS-1:0]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_act_prev_reg <= 7'h00;
		end else begin
			pin_act_prev_reg <= pin_act;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_edge_flag_reg <= 1'b0;
		end else if (!pin_edge_mode) begin
			pin_edge_flag_reg <= 1'b0;
		end else if (|pin_edges) begin
			pin_edge_flag_reg <= 1'b1;
		end else if (entry && sel_num == SRC_GPIO) begin
			pin_edge_flag_reg <= 1'b0;
		end
	end

	// ==================================
	// source masking, order 0..13
	assign src_raw = {src_req_i[13], pin_request_active,
		src_req_i[11:0]};

	// basic allows, extended allows, group gate
	assign src_allow = {extended_mask_reg, basic_mask_reg[5:0]};

	assign src_high = {1'b0, extended_priority_reg, basic_priority_reg};

	assign gate_open = basic_mask_reg[GLOBAL_ALLOW_BIT]
		& ~basic_mask_reg[GLOBAL_BLOCK_BIT];
	assign pend = src_raw & src_allow & {NUM_SRC{gate_open}};

	assign pick_high = first_set(pend & src_high);
	assign pick_low  = first_set(pend & ~src_high);

	// ==================================
	// running level and nesting
	assign top_is_high = (depth_reg == DEPTH_MAX) ? level_stack_reg[1]
		: level_stack_reg[0];
	assign high_level_running = (depth_reg != 2'h0) & top_is_high;
	assign low_level_running  = (depth_reg != 2'h0) & ~top_is_high;
	assign nesting_depth_flag = (depth_reg == 2'h1);

	assign can_high = ~high_level_running & (depth_reg != DEPTH_MAX);
	assign can_low  = (depth_reg == 2'h0);

	always_comb begin
		sel_valid = 1'b0;
		sel_num   = 4'h0;
		sel_high  = 1'b0;
		if (can_high && pick_high[4]) begin
			sel_valid = 1'b1;
			sel_num   = pick_high[3:0];
			sel_high  = 1'b1;
		end else if (can_low && pick_low[4]) begin
			sel_valid = 1'b1;
			sel_num   = pick_low[3:0];
		end
	end

	assign entry = take_i & irq_req_reg & sel_valid
		& (sel_num == irq_num_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			depth_reg       <= 2'h0;
			level_stack_reg <= 2'h0;
		end else if (entry) begin
			depth_reg <= depth_reg + 2'h1;
			if (depth_reg == 2'h0) begin
				level_stack_reg[0] <= sel_high;
			end else begin
				level_stack_reg[1] <= sel_high;
			end
		end else if (done_i && depth_reg != 2'h0) begin
			depth_reg <= depth_reg - 2'h1;
		end
	end

	// ==================================
	// core request outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_reg    <= 1'b0;
			irq_num_reg    <= 4'h0;
			irq_vector_reg <= 16'h0000;
			high_run_reg   <= 1'b0;
			low_run_reg    <= 1'b0;
		end else begin
			irq_req_reg  <= sel_valid & ~entry;
			irq_num_reg  <= sel_num;
			irq_vector_reg <= VEC_BASE
				+ 16'(VEC_STEP * {12'h000, sel_num});
			high_run_reg <= high_level_running;
			low_run_reg  <= low_level_running;
		end
	end

	// ==================================
	// event status, write one to clear
	assign evt_set = {(|pin_edges) & pin_edge_mode,
		entry & ~sel_high, entry & sel_high};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_status_reg <= RST_EVT;
			evt_mask_reg   <= RST_EVT;
		end else begin
			// set wins over clear
			if (wr_go && adr_i == OFS_EVT_STATUS) begin
				evt_status_reg <= (evt_status_reg & ~dat_i[2:0])
					| evt_set;
			end else begin
				evt_status_reg <= evt_status_reg | evt_set;
			end
			if (wr_go && adr_i == OFS_EVT_MASK) begin
				evt_mask_reg <= dat_i[2:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_reg <= 1'b0;
		end else begin
			int_reg <= |(evt_status_reg & evt_mask_reg);
		end
	end

	// ==================================
	// register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			basic_mask_reg        <= RST_MASK;
			extended_mask_reg     <= RST_MASK;
			pin_source_select_reg <= RST_SELECT;
			basic_priority_reg    <= RST_PRIO[5:0];
			extended_priority_reg <= RST_PRIO[6:0];
			serial1_pin_remap     <= RST_REMAP[1];
			serial0_pin_remap     <= RST_REMAP[0];
		end else if (wr_go) begin
			unique case (adr_i)
				OFS_BASIC_MASK: basic_mask_reg <= dat_i;
				OFS_EXT_MASK:   extended_mask_reg <= dat_i;
				OFS_PIN_SELECT: pin_source_select_reg <= dat_i;
				OFS_BASIC_PRIO: basic_priority_reg <= dat_i[5:0];
				OFS_EXT_PRIO:   extended_priority_reg <= dat_i[6:0];
				OFS_PIN_FUNC: begin
					serial1_pin_remap <= dat_i[SER1_REMAP_BIT];
					serial0_pin_remap <= dat_i[SER0_REMAP_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ==================================
	// bus answer and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_go;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= 8'h00;
		end else if (bus_go && !we_i) begin
			unique case (adr_i)
				OFS_BASIC_MASK: dat_reg <= basic_mask_reg;
				OFS_EXT_MASK:   dat_reg <= extended_mask_reg;
				OFS_PIN_SELECT: dat_reg <= pin_source_select_reg;
				OFS_BASIC_PRIO: begin
					dat_reg <= {high_level_running, low_level_running,
						basic_priority_reg};
				end
				OFS_EXT_PRIO: begin
					dat_reg <= {nesting_depth_flag,
						extended_priority_reg};
				end
				OFS_PIN_FUNC: begin
					dat_reg <= {1'b0, pin_request_active,
						serial1_pin_remap, serial0_pin_remap, 4'h0};
				end
				OFS_EVT_STATUS: begin
					dat_reg <= {5'h00, evt_status_reg};
				end
				OFS_EVT_MASK: begin
					dat_reg <= {5'h00, evt_mask_reg};
				end
				default: begin
					dat_reg <= 8'h00;
				end
			endcase
		end
	end

	assign dat_o        = dat_reg;
	assign ack_o        = ack_reg;
	assign int_o        = int_reg;
	assign irq_req_o    = irq_req_reg;
	assign irq_num_o    = irq_num_reg;
	assign irq_vector_o = irq_vector_reg;
	assign high_run_o   = high_run_reg;
	assign low_run_o    = low_run_reg;

endmodule

// ===== irq_unit_monitor.sv
// assertions on the interrupt unit ports
// assumes one clock domain, sync active-high reset
`timescale 1ns/1ps
module irq_unit_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic        int_o,
	input wire logic        take_i,
	input wire logic        done_i,
	input wire logic        irq_req_o,
	input wire logic [3:0]  irq_num_o,
	input wire logic [15:0] irq_vector_o,
	input wire logic        high_run_o,
	input wire logic        low_run_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// bus and reset
	a_ack_follows:
		assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	a_ack_single:
		assert property (ack_o |=> !ack_o) else $error("ack held");
	a_reset_clears:
		assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_req_o && !int_o)
			else $error("reset left outputs");
	// ==========
	// vector, number range and running flags
	a_vector_map:
		assert property (irq_req_o |-> irq_vector_o == 16'h0003 + {9'h000, irq_num_o, 3'h0})
			else $error("vector wrong");
	a_num_range:
		assert property (irq_req_o |-> irq_num_o <= 4'hD) else $error("number range");
	a_flags_legal:
		assert property (!(high_run_o && low_run_o)) else $error("flags both set");
	a_high_blocks:
		assert property (high_run_o |-> !irq_req_o) else $error("request over high");
	a_take_flags:
		assert property (take_i && irq_req_o && !done_i |=> ##1 (high_run_o || low_run_o))
			else $error("no running flag");
endmodule
bind irq_unit irq_unit_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .int_o, .take_i,
	.done_i, .irq_req_o, .irq_num_o, .irq_vector_o, .high_run_o, .low_run_o);

// ===== irq_unit_pkg.sv
// constants for the interrupt enable and priority unit
// assumes an 8-bit classic wishbone slave and one system clock
package irq_unit_pkg;

	// ==================================
	// register offsets (word index)
	localparam logic [3:0] OFS_BASIC_MASK  = 4'h0;
	localparam logic [3:0] OFS_EXT_MASK    = 4'h1;
	localparam logic [3:0] OFS_PIN_SELECT  = 4'h2;
	localparam logic [3:0] OFS_BASIC_PRIO  = 4'h3;
	localparam logic [3:0] OFS_EXT_PRIO    = 4'h4;
	localparam logic [3:0] OFS_PIN_FUNC    = 4'h5;
	localparam logic [3:0] OFS_EVT_STATUS  = 4'h6;
	localparam logic [3:0] OFS_EVT_MASK    = 4'h7;

	// ==================================
	// reset values
	localparam logic [7:0] RST_MASK   = 8'h00;
	localparam logic [7:0] RST_SELECT = 8'h00;
	localparam logic [7:0] RST_PRIO   = 8'h00;
	localparam logic [1:0] RST_REMAP  = 2'h0;
	localparam logic [2:0] RST_EVT    = 3'h0;

	// ==================================
	// field positions
	localparam int GLOBAL_ALLOW_BIT = 7;
	localparam int GLOBAL_BLOCK_BIT = 6;
	localparam int PIN_GROUP_BIT    = 6;
	localparam int PIN_EDGE_BIT     = 7;
	localparam int HIGH_RUN_BIT     = 7;
	localparam int LOW_RUN_BIT      = 6;
	localparam int NEST_FLAG_BIT    = 7;
	localparam int PIN_ACTIVE_BIT   = 6;
	localparam int SER1_REMAP_BIT   = 5;
	localparam int SER0_REMAP_BIT   = 4;
	localparam int EVT_HIGH_ENTRY   = 0;
	localparam int EVT_LOW_ENTRY    = 1;
	localparam int EVT_PIN_EDGE     = 2;

	// ==================================
	// sources and vectors
	localparam int         NUM_SRC     = 14;
	localparam int         NUM_PINS    = 7;
	localparam logic [3:0] SRC_GPIO    = 4'hC;
	localparam logic [15:0] VEC_BASE   = 16'h0003;
	localparam logic [15:0] VEC_STEP   = 16'h0008;
	localparam logic [1:0] DEPTH_MAX   = 2'h2;

endpackage

// ===== tb.sv
// bench for the interrupt unit over classic wishbone
// assumes core_model on the core link and the bound checker
`timescale 1ns/1ps
module tb;
	import irq_unit_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic        we_i = 1'b0, sel_i = 1'b0, go = 1'b0, ret = 1'b0, probe = 1'b0;
	logic        ack_o, int_o, take_i, done_i, irq_req_o, high_run_o, low_run_o;
	logic        exp_int = 1'b0;
	logic [3:0]  adr_i = 4'h0, irq_num_o, wait_c = 4'h0;
	logic [7:0]  dat_i = 8'h00, dat_o, r;
	logic [8:0]  pin = 9'h0FF;
	logic [13:0] src_req_i = 14'h0000;
	logic [15:0] irq_vector_o;
	logic [21:0] e, g;
	logic [7:0]  rq[$];
	logic [21:0] pq[$];
	logic [7:0]  sb[9] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h40};
	logic [7:0]  fn[9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
	int          px[9] = '{5, 0, 6, 8, 1, 2, 3, 4, 7};
	int          fail_count = 0, total_checks = 0, seed = 67151;
	always #25 clk_i = ~clk_i;
	irq_unit uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i, .dat_o,
		.ack_o, .int_o, .src_req_i, .p1_2_i(pin[0]), .p1_3_i(pin[1]), .p1_4_i(pin[2]),
		.p1_5_i(pin[3]), .p1_6_i(pin[4]), .p3_0_i(pin[5]), .p3_1_i(pin[6]), .p3_4_i(pin[7]),
		.rst_pin_i(pin[8]), .take_i, .done_i, .irq_req_o, .irq_num_o, .irq_vector_o,
		.high_run_o, .low_run_o);
	core_model core (.clk_i, .rst_i, .req_i(irq_req_o), .go_i(go), .wait_i(wait_c),
		.ret_i(ret), .take_o(take_i), .done_o(done_i));
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// ==========
	// result watcher
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && !we_i && rq.size() > 0)
			cmp({14'h0000, dat_o}, {14'h0000, rq.pop_front()});
		if (probe) begin
			e = pq.pop_front();
			g = {int_o, irq_req_o, irq_num_o, irq_vector_o};
			if (!e[20])
				g[19:0] = e[19:0];
			cmp(g, e);
		end
	end
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= s;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			test_done();
		end
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 1'b1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		rq.push_back(x);
		wb(1'b0, a, 8'h00, 1'b1);
	endtask
	task automatic chk(input logic q, input logic [3:0] n);
		repeat (4) @(posedge clk_i);
		pq.push_back({exp_int, q, n, VEC_BASE + VEC_STEP * {12'h000, n}});
		probe <= 1'b1;
		@(posedge clk_i);
		probe <= 1'b0;
	endtask
	task automatic take(input logic [3:0] w);
		int n;
		n = 0;
		wait_c <= w;
		go <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (take_i !== 1'b1 && n < 50);
		go <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			test_done();
		end
	endtask
	task automatic retn();
		ret <= 1'b1;
		@(posedge clk_i);
		ret <= 1'b0;
		@(posedge clk_i);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// ==========
		// reset values, access kinds, unmapped and unselected writes
		for (int a = 0; a < 9; a++)
			rd(a[3:0], 8'h00);
		for (int a = 0; a < 5; a++) begin
			r = $random(seed);
			wr(a[3:0], r);
			rd(a[3:0], a == 3 ? r & 8'h3F : a == 4 ? r & 8'h7F : r);
		end
		wr(4'h9, 8'hA5);
		rd(4'h9, 8'h00);
		wr(OFS_EXT_MASK, 8'hFF);
		wb(1'b1, OFS_EXT_MASK, 8'h00, 1'b0);
		rd(OFS_EXT_MASK, 8'hFF);
		wr(OFS_PIN_SELECT, 8'h00);
		wr(OFS_BASIC_PRIO, 8'h00);
		wr(OFS_EXT_PRIO, 8'h00);
		// ==========
		// each source alone except the pin group: allow, global gate, own mask
		for (int s = 0; s < 14; s++) begin
			if (s == 12)
				continue;
			src_req_i <= 14'h0001 << s;
			wr(OFS_BASIC_MASK, 8'hBF);
			chk(1'b1, s[3:0]);
			wr(OFS_BASIC_MASK, s[0] ? 8'hFF : 8'h3F);
			chk(1'b0, 4'h0);
			wr(OFS_BASIC_MASK, 8'hBF & ~(s < 6 ? 8'h01 << s : 8'h00));
			wr(OFS_EXT_MASK, s < 6 ? 8'hFF : ~(8'h01 << (s - 6)));
			chk(1'b0, 4'h0);
			wr(OFS_EXT_MASK, 8'hFF);
		end
		// ==========
		// levels, default order, nesting and events
		wr(OFS_BASIC_MASK, 8'hBF);
		src_req_i <= 14'h2FFF;
		wr(OFS_EXT_PRIO, 8'h10);
		chk(1'b1, 4'hA);
		wr(OFS_BASIC_PRIO, 8'h20);
		chk(1'b1, 4'h5);
		wr(OFS_BASIC_PRIO, 8'h00);
		wr(OFS_EXT_PRIO, 8'h00);
		chk(1'b1, 4'h0);
		take(4'h0);
		chk(1'b0, 4'h0);
		rd(OFS_BASIC_PRIO, 8'h40);
		rd(OFS_EXT_PRIO, 8'h80);
		wr(OFS_EXT_PRIO, 8'h01);
		chk(1'b1, 4'h6);
		take(4'h3);
		rd(OFS_BASIC_PRIO, 8'h80);
		rd(OFS_EXT_PRIO, 8'h01);
		rd(OFS_EVT_STATUS, 8'h03);
		wr(OFS_EVT_MASK, 8'h01);
		exp_int = 1'b1;
		chk(1'b0, 4'h0);
		wr(OFS_EVT_STATUS, 8'h01);
		exp_int = 1'b0;
		rd(OFS_EVT_STATUS, 8'h02);
		src_req_i <= 14'h2FBF;
		retn();
		chk(1'b0, 4'h0);
		rd(OFS_EXT_PRIO, 8'h81);
		retn();
		chk(1'b1, 4'h0);
		src_req_i <= 14'h0000;
		// ==========
		// pin sources: level, group gate, edge latch, remap
		wr(OFS_BASIC_MASK, 8'h80);
		wr(OFS_EXT_MASK, 8'h40);
		for (int k = 0; k < 9; k++) begin
			wr(OFS_PIN_FUNC, fn[k]);
			wr(OFS_PIN_SELECT, sb[k]);
			pin[px[k]] <= ~pin[px[k]];
			chk(1'b1, SRC_GPIO);
			rd(OFS_PIN_FUNC, fn[k] | 8'h40);
			wr(OFS_EXT_MASK, 8'h00);
			chk(1'b0, 4'h0);
			wr(OFS_EXT_MASK, 8'h40);
			pin[px[k]] <= ~pin[px[k]];
			chk(1'b0, 4'h0);
			wr(OFS_PIN_SELECT, sb[k] | 8'h80);
			pin[px[k]] <= ~pin[px[k]];
			@(posedge clk_i);
			pin[px[k]] <= ~pin[px[k]];
			chk(1'b1, SRC_GPIO);
			take(4'h1);
			chk(1'b0, 4'h0);
			retn();
			chk(1'b0, 4'h0);
			rd(OFS_PIN_FUNC, fn[k]);
		end
		rd(OFS_EVT_STATUS, 8'h06);
		test_done();
	end
endmodule
